// >>> rtl/timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
// Register offsets (byte addresses on the plain port)
`define OFS_CTRL 8'h40
`define OFS_CNT_HI 8'h41
`define OFS_CNT_LO 8'h42
`define OFS_MOD_HI 8'h43
`define OFS_MOD_LO 8'h44
`define OFS_CH0_SC 8'h45
`define OFS_CH0_HI 8'h46
`define OFS_CH0_LO 8'h47
`define OFS_CH1_SC 8'h48
`define OFS_CH1_HI 8'h49
`define OFS_CH1_LO 8'h4a
// Control register fields
`define CTRL_OVF_FLAG 7
`define CTRL_OVF_IE 6
`define CTRL_HALT 5
`define CTRL_CLEAR 4
`define CTRL_RESET 8'h20
// Channel status/control fields
`define SC_FLAG 7
`define SC_IE 6
`define SC_BUF 5
`define SC_MODE_A 4
`define SC_EDGE_HI 3
`define SC_EDGE_LO 2
`define SC_TOV 1
`define SC_MAX 0
`define SC_RESET 8'h00
`define MOD_RESET 16'hffff
`endif

// >>> rtl/timer_pkg.sv
package timer_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        logic flag;
        logic ie;
        logic buf_sel;
        logic mode_a;
        logic [1:0] edge_sel;
        logic tov;
        logic max;
    } chan_sc_t;
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage : timer_pkg

// >>> rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module pin_sync (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [2:0] warm_reg;
    wire agree = (s2_reg == s3_reg);
    // Edges masked until the chain holds the real pin level after reset
    wire warm = (warm_reg == 3'h4);
    // Sync chain and filtered level
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
            warm_reg <= 3'h0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (!warm) warm_reg <= warm_reg + 3'h1;
            if (agree || !warm) lvl_reg <= s3_reg;
        end
    end
    assign level_o = lvl_reg;
    assign rise_o = warm && agree && s3_reg && !lvl_reg;
    assign fall_o = warm && agree && !s3_reg && lvl_reg;
endmodule : pin_sync
`default_nettype wire

// >>> rtl/chan_output.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"
// One channel output latch: init level, compare action, overflow toggle, full duty
module chan_output
    import timer_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire chan_sc_t sc_i,
    input wire logic enabled_i,
    input wire logic compare_i,
    input wire logic overflow_i,
    output logic out_o
);
    logic out_reg, out_next, max_reg;
    wire [1:0] act = sc_i.edge_sel;
    wire cmp_out = (act == 2'b01) ? ~out_reg : (act == 2'b11);
    // Next output level
    always_comb begin
        out_next = out_reg;
        if (!enabled_i) begin
            out_next = ~sc_i.mode_a;
        end else if (overflow_i && sc_i.tov) begin
            out_next = ~out_reg;
        end else if (overflow_i && max_reg) begin
            out_next = 1'b1;
        end else if (compare_i && !max_reg) begin
            out_next = cmp_out;
        end
    end
    // Output latch; full duty latched at period start
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_reg <= 1'b1;
            max_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            if (overflow_i || !enabled_i) max_reg <= sc_i.max && !sc_i.tov;
        end
    end
    assign out_o = out_reg;
endmodule : chan_output
`default_nettype wire

// >>> rtl/timer_channels.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"
module timer_channels
    import timer_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] pin_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o,
    output logic [1:0] chan_irq_o,
    output logic ovf_irq_o
);
    // ***************************************
    // Bus decode
    // ***************************************
    bus_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit
    wire wr_ctrl = req.wr && hit(req.addr, `OFS_CTRL);
    wire rd_ctrl = req.rd && hit(req.addr, `OFS_CTRL);
    wire wr_mod_hi = req.wr && hit(req.addr, `OFS_MOD_HI);
    wire wr_mod_lo = req.wr && hit(req.addr, `OFS_MOD_LO);
    wire [1:0] wr_sc = {req.wr && hit(req.addr, `OFS_CH1_SC), req.wr && hit(req.addr, `OFS_CH0_SC)};
    wire [1:0] rd_sc = {req.rd && hit(req.addr, `OFS_CH1_SC), req.rd && hit(req.addr, `OFS_CH0_SC)};
    wire [1:0] wr_val_hi = {req.wr && hit(req.addr, `OFS_CH1_HI), req.wr && hit(req.addr, `OFS_CH0_HI)};
    wire [1:0] wr_val_lo = {req.wr && hit(req.addr, `OFS_CH1_LO), req.wr && hit(req.addr, `OFS_CH0_LO)};
    wire [1:0] rd_val_hi = {req.rd && hit(req.addr, `OFS_CH1_HI), req.rd && hit(req.addr, `OFS_CH0_HI)};
    wire [1:0] rd_val_lo = {req.rd && hit(req.addr, `OFS_CH1_LO), req.rd && hit(req.addr, `OFS_CH0_LO)};

    // ***************************************
    // State
    // ***************************************
    logic [7:0] ctrl_reg;
    logic [15:0] count_reg, modulo_reg, cnt_snap_reg;
    logic [7:0] mod_hi_buf_reg;
    logic mod_lock_reg, ovf_armed_reg;
    chan_sc_t sc_reg [2];
    logic [15:0] val_reg [2];
    logic [7:0] val_hi_buf_reg [2];
    logic [1:0] armed_reg, cap_lock_reg, cmp_lock_reg;
    logic buf_phase_reg;
    logic [7:0] rdata_reg;
    logic [1:0] pin_reg, pin_oe_reg, chan_irq_reg;
    logic ovf_irq_reg;

    // ***************************************
    // Counter and overflow
    // ***************************************
    wire halt = ctrl_reg[`CTRL_HALT];
    wire clear_cmd = wr_ctrl && wdata_i[`CTRL_CLEAR];
    wire mod_match = !halt && (count_reg == modulo_reg);
    // Flag held off while modulo half written
    wire ovf_event = mod_match && !mod_lock_reg;
    wire [15:0] count_next = clear_cmd ? 16'h0000 : halt ? count_reg :
                             mod_match ? 16'h0000 : count_reg + 16'h0001;

    // ***************************************
    // Channel decode
    // ***************************************
    wire buffered = sc_reg[0].buf_sel;
    logic [1:0] enabled, capture, compare_ch, cap_edge, cmp_hit, ch_event;
    logic [1:0] sync_rise, sync_fall;
    logic [1:0] out_lvl;
    chan_sc_t sc_eff [2];
    // Effective controls; channel 1 idle in buffered mode
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sc_eff[i] = sc_reg[i];
            // Edge 00 leaves pin on port
            enabled[i] = (sc_reg[i].edge_sel != 2'b00) && !(i == 1 && buffered);
            capture[i] = enabled[i] && !sc_reg[i].mode_a && !(i == 0 && buffered);
            compare_ch[i] = enabled[i] && !capture[i];
            cap_edge[i] = (sc_reg[i].edge_sel[0] && sync_rise[i]) || (sc_reg[i].edge_sel[1] && sync_fall[i]);
            cmp_hit[i] = 1'b0;
        end
        if (buffered) begin
            cmp_hit[0] = !halt && !cmp_lock_reg[buf_phase_reg] && (count_reg == val_reg[buf_phase_reg]);
        end else begin
            cmp_hit[0] = !halt && !cmp_lock_reg[0] && (count_reg == val_reg[0]);
        end
        cmp_hit[1] = !halt && !cmp_lock_reg[1] && (count_reg == val_reg[1]);
        for (int i = 0; i < 2; i++) begin
            ch_event[i] = (capture[i] && !halt && !cap_lock_reg[i] && cap_edge[i]) ||
                          (compare_ch[i] && cmp_hit[i]);
        end
    end

    // Synchronisers and output latches
    for (genvar g = 0; g < 2; g++) begin : g_ch
        pin_sync u_sync (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .pin_i(pin_i[g]),
            .level_o(),
            .rise_o(sync_rise[g]),
            .fall_o(sync_fall[g])
        );
        chan_output u_out (
            .ref_clk_i(ref_clk_i),
            .reset_i(reset_i),
            .sc_i(sc_eff[g]),
            .enabled_i(compare_ch[g]),
            .compare_i(cmp_hit[g]),
            .overflow_i(mod_match),
            .out_o(out_lvl[g])
        );
    end

    // ***************************************
    // Read mux
    // ***************************************
    function automatic logic [7:0] sc_byte(input chan_sc_t s, input logic ch1);
        sc_byte = ch1 ? {s.flag, s.ie, 1'b0, s.mode_a, s.edge_sel, s.tov, s.max} : s;
    endfunction : sc_byte
    logic [7:0] rdata_next;
    always_comb begin
        unique case (addr_i)
            `OFS_CTRL: rdata_next = {ctrl_reg[7:5], 1'b0, ctrl_reg[3:0]};
            `OFS_CNT_HI: rdata_next = count_reg[15:8];
            `OFS_CNT_LO: rdata_next = cnt_snap_reg[7:0];
            `OFS_MOD_HI: rdata_next = modulo_reg[15:8];
            `OFS_MOD_LO: rdata_next = modulo_reg[7:0];
            `OFS_CH0_SC: rdata_next = sc_byte(sc_reg[0], 1'b0);
            `OFS_CH0_HI: rdata_next = val_reg[0][15:8];
            `OFS_CH0_LO: rdata_next = val_reg[0][7:0];
            `OFS_CH1_SC: rdata_next = sc_byte(sc_reg[1], 1'b1);
            `OFS_CH1_HI: rdata_next = val_reg[1][15:8];
            `OFS_CH1_LO: rdata_next = val_reg[1][7:0];
            default: rdata_next = 8'h00;
        endcase
    end

    // ***************************************
    // Counter, control and modulo
    // ***************************************
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_reg <= `CTRL_RESET;
            count_reg <= 16'h0000;
            cnt_snap_reg <= 16'h0000;
            modulo_reg <= `MOD_RESET;
            mod_hi_buf_reg <= 8'hff;
            mod_lock_reg <= 1'b0;
            ovf_armed_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            if (req.rd && hit(req.addr, `OFS_CNT_HI)) cnt_snap_reg <= count_reg;
            if (rd_ctrl) ovf_armed_reg <= ctrl_reg[`CTRL_OVF_FLAG];
            // New overflow cancels a pending clear
            if (ovf_event) begin
                ovf_armed_reg <= 1'b0;
            end
            // Overflow flag: set beats clear
            if (ovf_event) begin
                ctrl_reg[`CTRL_OVF_FLAG] <= 1'b1;
            end else if (wr_ctrl && !wdata_i[`CTRL_OVF_FLAG] && ovf_armed_reg) begin
                ctrl_reg[`CTRL_OVF_FLAG] <= 1'b0;
            end
            if (wr_ctrl) begin
                ctrl_reg[6:5] <= wdata_i[6:5];
                ctrl_reg[3:0] <= wdata_i[3:0];
                ovf_armed_reg <= 1'b0;
            end
            if (wr_mod_hi) begin
                mod_hi_buf_reg <= wdata_i;
                mod_lock_reg <= 1'b1;
            end
            if (wr_mod_lo) begin
                modulo_reg <= {mod_hi_buf_reg, wdata_i};
                mod_lock_reg <= 1'b0;
            end
        end
    end

    // ***************************************
    // Channel registers
    // ***************************************
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 2; i++) begin
                sc_reg[i] <= `SC_RESET;
                val_reg[i] <= 16'h0000;
                val_hi_buf_reg[i] <= 8'h00;
            end
            armed_reg <= 2'b00;
            cap_lock_reg <= 2'b00;
            cmp_lock_reg <= 2'b00;
            buf_phase_reg <= 1'b0;
        end else begin
            if (buffered && cmp_hit[0]) buf_phase_reg <= ~buf_phase_reg;
            if (!buffered) buf_phase_reg <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (rd_sc[i]) armed_reg[i] <= sc_reg[i].flag;
                if (ch_event[i]) begin
                    armed_reg[i] <= 1'b0;
                end
                if (ch_event[i]) begin
                    sc_reg[i].flag <= 1'b1;
                end else if (wr_sc[i] && !wdata_i[`SC_FLAG] && armed_reg[i] && !sc_reg[i].ie) begin
                    sc_reg[i].flag <= 1'b0;
                end
                if (wr_sc[i]) begin
                    armed_reg[i] <= 1'b0;
                    sc_reg[i].ie <= wdata_i[`SC_IE];
                    // Buffer select on channel 0 only
                    sc_reg[i].buf_sel <= (i == 0) ? wdata_i[`SC_BUF] : 1'b0;
                    sc_reg[i].mode_a <= wdata_i[`SC_MODE_A];
                    sc_reg[i].edge_sel <= wdata_i[`SC_EDGE_HI:`SC_EDGE_LO];
                    sc_reg[i].tov <= wdata_i[`SC_TOV];
                    sc_reg[i].max <= wdata_i[`SC_MAX];
                end
                if (capture[i] && ch_event[i]) val_reg[i] <= count_reg;
                if (rd_val_hi[i] && capture[i]) cap_lock_reg[i] <= 1'b1;
                if (rd_val_lo[i]) cap_lock_reg[i] <= 1'b0;
                if (wr_val_hi[i]) begin
                    val_hi_buf_reg[i] <= wdata_i;
                    cmp_lock_reg[i] <= 1'b1;
                end
                if (wr_val_lo[i]) begin
                    val_reg[i] <= {val_hi_buf_reg[i], wdata_i};
                    cmp_lock_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ***************************************
    // Registered outputs
    // ***************************************
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= 8'h00;
            pin_reg <= 2'b00;
            pin_oe_reg <= 2'b00;
            chan_irq_reg <= 2'b00;
            ovf_irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 8'h00;
            pin_reg <= out_lvl;
            pin_oe_reg <= compare_ch;
            chan_irq_reg <= {sc_reg[1].flag && sc_reg[1].ie, sc_reg[0].flag && sc_reg[0].ie};
            ovf_irq_reg <= ctrl_reg[`CTRL_OVF_FLAG] && ctrl_reg[`CTRL_OVF_IE];
        end
    end
    assign rdata_o = rdata_reg;
    assign pin_o = pin_reg;
    assign pin_oe_o = pin_oe_reg;
    assign chan_irq_o = chan_irq_reg;
    assign ovf_irq_o = ovf_irq_reg;
endmodule : timer_channels
`default_nettype wire

// >>> bench/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Far-side pin drivers
// ****************
module pin_partner (
    input wire logic [1:0] level_i,
    input wire logic [1:0] drv_i,
    input wire logic [1:0] drv_oe_i,
    output logic [1:0] line_o
);
    // stable outside level
    // Outside level changes only on bench command; channel wins while driving
    assign line_o = (drv_oe_i & drv_i) | (~drv_oe_i & level_i);
endmodule : pin_partner
`default_nettype wire

// >>> bench/timer_channels_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checker
// ****************
module timer_channels_checker (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] pin_i,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe_o,
    input wire logic [1:0] chan_irq_o,
    input wire logic ovf_irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic [2:0] sc0_wr_reg;
    // Channel 0 control write decode
    wire logic sc0_wr = wr_i && addr_i == 8'h45;
    wire logic sc0_cfg = sc0_wr && !wdata_i[5] && wdata_i[3:2] != 2'h0;
    // History of channel 0 control writes
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sc0_wr_reg <= 3'h0;
        end else begin
            sc0_wr_reg <= {sc0_wr_reg[1:0], sc0_wr};
        end
    end
    ch1_buf_bit_a: assert property (rd_i && addr_i == 8'h48 |=> !rdata_o[5])
        else $error("channel 1 buffered bit read as one");
    clear_reads_zero_a: assert property (rd_i && addr_i == 8'h40 |=> !rdata_o[4])
        else $error("counter clear bit read as one");
    pin_release_a: assert property (sc0_wr && wdata_i[3:2] == 2'h0 |-> ##[1:3] !pin_oe_o[0])
        else $error("channel 0 pin not released");
    buf_frees_ch1_a: assert property (sc0_wr && wdata_i[5] |-> ##[1:3] !pin_oe_o[1])
        else $error("channel 1 pin still driven in buffered mode");
    irq_needs_en_a: assert property (sc0_wr && !wdata_i[6] |-> ##[1:3] !chan_irq_o[0])
        else $error("channel 0 request without enable");
    irq_held_a: assert property ($fell(chan_irq_o[0]) |-> sc0_wr_reg != 3'h0)
        else $error("channel 0 request dropped without control write");
    cmp_drives_a: assert property (sc0_cfg && wdata_i[4] |-> ##[1:3] pin_oe_o[0])
        else $error("compare channel 0 not driving pin");
    cap_no_drive_a: assert property (sc0_cfg && !wdata_i[4] |-> ##[1:3] !pin_oe_o[0])
        else $error("capture channel 0 driving pin");
    cover property ($rose(chan_irq_o[0]));
    cover property ($rose(ovf_irq_o));
    cover property ($rose(pin_oe_o[1]));
endmodule : timer_channels_checker
bind timer_channels timer_channels_checker chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .chan_irq_o(chan_irq_o),
    .ovf_irq_o(ovf_irq_o));
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Timer channel bench
// ****************
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] level = 2'h0;
    logic [7:0] rdata;
    logic [1:0] line;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic [1:0] chan_irq;
    logic ovf_irq;
    logic [7:0] v;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    timer_channels DUT (.ref_clk_i(ref_clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_i(line), .pin_o(pin_o), .pin_oe_o(pin_oe),
        .chan_irq_o(chan_irq), .ovf_irq_o(ovf_irq));
    pin_partner far_end (.level_i(level), .drv_i(pin_o), .drv_oe_i(pin_oe), .line_o(line));
    // Clock generation
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Read one byte; data stands in the following cycle
    task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        v = rdata;
        chk(what, exp, v);
    endtask : chk_reg
    task automatic t_reset();
        chk_reg("mod_hi", 8'h43, 8'hff);
        chk_reg("mod_lo", 8'h44, 8'hff);
        chk_reg("sc0", 8'h45, 8'h00);
        chk_reg("sc1", 8'h48, 8'h00);
        chk_reg("ctrl", 8'h40, 8'h20);
        chk_reg("unmapped", 8'h50, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_overflow();
        wr_reg(8'h40, 8'h30);
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h44, 8'h05);
        wr_reg(8'h40, 8'h10);
        repeat (12) @(posedge ref_clk);
        wr_reg(8'h40, 8'h20);
        chk_reg("ovf flag", 8'h40, 8'ha0);
        wr_reg(8'h40, 8'h30);
        chk_reg("ovf cleared", 8'h40, 8'h20);
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h40, 8'h40);
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk) chk("ovf masked", 8'h00, {7'h0, ovf_irq});
        wr_reg(8'h44, 8'h05);
        wr_reg(8'h40, 8'h50);
        for (int i = 0; i < 20 && ovf_irq !== 1'b1; i++) @(posedge ref_clk);
        @(negedge ref_clk) chk("ovf irq", 8'h01, {7'h0, ovf_irq});
        wr_reg(8'h40, 8'h00);
        $display("test overflow done");
    endtask : t_overflow
    task automatic t_capture();
        logic [7:0] c;
        for (int e = 1; e < 4; e++) begin
            c = 8'(e << 2);
            level[0] <= 1'b0;
            wr_reg(8'h45, c);
            repeat (4) @(posedge ref_clk);
            level[0] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk_reg("rise", 8'h45, c | (e[0] ? 8'h80 : 8'h00));
            wr_reg(8'h45, c);
            level[0] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            chk_reg("fall", 8'h45, c | (e[1] ? 8'h80 : 8'h00));
            wr_reg(8'h45, c);
        end
        wr_reg(8'h45, 8'h4c);
        level[0] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk) chk("ch0 irq", 8'h01, {7'h0, chan_irq[0]});
        chk_reg("flag ie", 8'h45, 8'hcc);
        wr_reg(8'h45, 8'h4c);
        chk_reg("kept ie", 8'h45, 8'hcc);
        wr_reg(8'h45, 8'h8c);
        chk_reg("kept one", 8'h45, 8'h8c);
        chk("irq off", 8'h00, {7'h0, chan_irq[0]});
        wr_reg(8'h45, 8'h0c);
        chk_reg("cleared", 8'h45, 8'h0c);
        @(posedge ref_clk) level[0] <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk_reg("flag again", 8'h45, 8'h8c);
        @(posedge ref_clk) level[0] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wr_reg(8'h45, 8'h0c);
        chk_reg("clear cancelled", 8'h45, 8'h8c);
        $display("test capture done");
    endtask : t_capture
    task automatic t_compare();
        logic p;
        wr_reg(8'h49, 8'h00);
        wr_reg(8'h4a, 8'h03);
        for (int a = 1; a < 4; a++) begin
            wr_reg(8'h48, 8'h10 | 8'(a << 2));
            repeat (12) @(negedge ref_clk);
            p = pin_o[1];
            chk("ch1 oe", 8'h01, {7'h0, pin_oe[1]});
            if (a == 1) begin
                repeat (6) @(negedge ref_clk);
                chk("toggle", {7'h0, ~p}, {7'h0, pin_o[1]});
            end else begin
                chk("level", 8'(a - 2), {7'h0, p});
            end
        end
        chk_reg("cmp flag", 8'h48, 8'h9c);
        wr_reg(8'h48, 8'h59);
        repeat (14) @(posedge ref_clk);
        @(negedge ref_clk) chk("ch1 irq", 8'h01, {7'h0, chan_irq[1]});
        repeat (6) @(negedge ref_clk) chk("full", 8'h01, {7'h0, pin_o[1]});
        wr_reg(8'h48, 8'h18);
        repeat (14) @(negedge ref_clk);
        chk("duty back", 8'h00, {7'h0, pin_o[1]});
        $display("test compare done");
    endtask : t_compare
    task automatic t_buffer();
        logic p;
        wr_reg(8'h46, 8'h00);
        wr_reg(8'h47, 8'h01);
        wr_reg(8'h40, 8'h30);
        wr_reg(8'h45, 8'h34);
        wr_reg(8'h40, 8'h00);
        repeat (4) @(negedge ref_clk);
        chk("ch1 free", 8'h00, {7'h0, pin_oe[1]});
        chk("ch0 drive", 8'h01, {7'h0, pin_oe[0]});
        p = pin_o[0];
        repeat (6) @(negedge ref_clk);
        chk("two toggles", {7'h0, p}, {7'h0, pin_o[0]});
        wr_reg(8'h40, 8'h30);
        wr_reg(8'h45, 8'h14);
        wr_reg(8'h45, 8'h10);
        repeat (4) @(negedge ref_clk);
        chk("ch0 free", 8'h00, {7'h0, pin_oe[0]});
        chk("preset low", 8'h00, {7'h0, pin_o[0]});
        $display("test buffer done");
    endtask : t_buffer
    // Main sequence with a second reset after the last test, then the reset values checked again
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_overflow();
        t_capture();
        t_compare();
        t_buffer();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        results();
    end
endmodule : tb_top
`default_nettype wire
